// *** inc/pbf_regs.svh ***
// register offsets, field positions and reset values for the port b/f pin mux
`ifndef PBF_REGS_SVH
`define PBF_REGS_SVH

`define PBF_ADDR_W 4
`define PBF_ADDR_B_PER 4'h0
`define PBF_ADDR_B_DDR 4'h1
`define PBF_ADDR_B_DR 4'h2
`define PBF_ADDR_B_PUR 4'h3
`define PBF_ADDR_B_PIN 4'h4
`define PBF_ADDR_F_PER 4'h5
`define PBF_ADDR_F_DDR 4'h6
`define PBF_ADDR_F_DR 4'h7
`define PBF_ADDR_F_PUR 4'h8
`define PBF_ADDR_F_PIN 4'h9
`define PBF_ADDR_CLKO 4'ha
`define PBF_ADDR_BUSCTL 4'hb

`define PBF_B_PER_RST 5'h1f
`define PBF_F_PER_RST 4'hf
`define PBF_B_PUR_RST 5'h1f
`define PBF_F_PUR_RST 4'hf
`define PBF_CLKO_RST 3'h0
`define PBF_BUSCTL_RST 1'h1

`define PBF_B_CLK_PIN 4
`define PBF_CLKO_ADDR_BIT 3

`define PBF_SRC_W 5
`define PBF_SRC_SYS 0
`define PBF_SRC_IPB 1
`define PBF_SRC_OSC 2
`define PBF_SRC_PRE 3
`define PBF_SRC_POST 4

`endif

// *** inc/pbf_pkg.sv ***
// types shared by the port b/f pin mux
`default_nettype none
package pbf_pkg;
  // clock-out selection codes
  typedef enum logic [2:0] {
    PBF_CLKO_OFF = 3'h0,
    PBF_CLKO_SYS = 3'h1,
    PBF_CLKO_IPB = 3'h2,
    PBF_CLKO_OSC = 3'h3,
    PBF_CLKO_PRE = 3'h4,
    PBF_CLKO_POST = 3'h5
  } pbf_clko_t;
endpackage : pbf_pkg
`default_nettype wire

// *** src/pbf_pin_cell.sv ***
// one pad cell: function select, output drive, enable and input synchroniser
`default_nettype none
module pbf_pin_cell (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // control
  input wire logic gpio_sel_in,
  input wire logic gpio_dir_in,
  input wire logic gpio_dat_in,
  input wire logic pu_en_in,
  input wire logic alt_val_in,
  input wire logic alt_oe_in,
  // pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe_out,
  output logic pad_pu_out,
  output logic sync_out
);
  logic meta_ff;
  logic sync_ff;
  wire nxt_pad = gpio_sel_in ? gpio_dat_in : alt_val_in;
  wire nxt_oe = gpio_sel_in ? gpio_dir_in : alt_oe_in;

  // registered pad drive so outputs come from flops
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pad_out <= 1'b0;
      pad_oe_out <= 1'b0;
      pad_pu_out <= 1'b1;
    end
    else if (ce_in)
    begin
      pad_out <= nxt_pad;
      pad_oe_out <= nxt_oe;
      pad_pu_out <= pu_en_in;
    end
  end

  // two flops since the pad is asynchronous
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      meta_ff <= pad_in;
      sync_ff <= meta_ff;
    end
  end
  assign sync_out = sync_ff;
endmodule : pbf_pin_cell
`default_nettype wire

// *** src/pbf_pin_mux.sv ***
// port b pins 0-4 and port f pins 0-3 function select with register port
//
// Chosen here: strobed register access and the address map.
`include "pbf_regs.svh"
`default_nettype none
// Functional notes
// - each port b pin selectable input/output
// - port b resets to general-purpose function
// - clearing pull-up bit n disables pin n pull-up
// - address pins tri-state when bus idle, if enabled
// - data pins tri-state when bus idle, if enabled
// - port f resets to data bus function
// - port f gpio pins selectable input/output
// - release gpio on pin 4 before alternate use
// - clock-out select picks address or prescaler clock
// - clock-out offers six source choices
module pbf_pin_mux #(
  parameter int NB = 5,
  parameter int NF = 4
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // register port
  input wire logic [`PBF_ADDR_W-1:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // external bus core side
  input wire logic bus_active_in,
  input wire logic [NB-1:0] addr_hi_in,
  input wire logic [NF-1:0] data_wr_in,
  input wire logic data_dir_out_in,
  output logic [NF-1:0] data_rd_out,
  output logic bus_float_out,
  // clock sources
  input wire logic sys_clk_in,
  input wire logic ipb_clk_in,
  input wire logic osc_clk_in,
  input wire logic pre_clk_in,
  input wire logic post_clk_in,
  output logic clko_out,
  // port b pads
  input wire logic [NB-1:0] pb_pad_in,
  output logic [NB-1:0] pb_pad_out,
  output logic [NB-1:0] pb_pad_oe_out,
  output logic [NB-1:0] pb_pu_out,
  // port f pads
  input wire logic [NF-1:0] pf_pad_in,
  output logic [NF-1:0] pf_pad_out,
  output logic [NF-1:0] pf_pad_oe_out,
  output logic [NF-1:0] pf_pu_out
);
  logic [NB-1:0] b_per_ff;
  logic [NB-1:0] b_ddr_ff;
  logic [NB-1:0] b_dr_ff;
  logic [NB-1:0] b_pur_ff;
  logic [NF-1:0] f_per_ff;
  logic [NF-1:0] f_ddr_ff;
  logic [NF-1:0] f_dr_ff;
  logic [NF-1:0] f_pur_ff;
  pbf_pkg::pbf_clko_t clko_sel_ff;
  logic clko_addr_ff;
  logic drv_ff;
  logic clko_ff;
  logic float_ff;
  logic [NB-1:0] b_sync;
  logic [NF-1:0] f_sync;
  logic [15:0] nxt_rdata;

  // write decode
  wire wr_b_per = wr_in && (addr_in == `PBF_ADDR_B_PER);
  wire wr_b_ddr = wr_in && (addr_in == `PBF_ADDR_B_DDR);
  wire wr_b_dr = wr_in && (addr_in == `PBF_ADDR_B_DR);
  wire wr_b_pur = wr_in && (addr_in == `PBF_ADDR_B_PUR);
  wire wr_f_per = wr_in && (addr_in == `PBF_ADDR_F_PER);
  wire wr_f_ddr = wr_in && (addr_in == `PBF_ADDR_F_DDR);
  wire wr_f_dr = wr_in && (addr_in == `PBF_ADDR_F_DR);
  wire wr_f_pur = wr_in && (addr_in == `PBF_ADDR_F_PUR);
  wire wr_clko = wr_in && (addr_in == `PBF_ADDR_CLKO);
  wire wr_busctl = wr_in && (addr_in == `PBF_ADDR_BUSCTL);

  // unknown select codes fall back to off so no junk toggles the pin
  wire [2:0] wsel = wdata_in[2:0];
  wire sel_legal = (wsel <= 3'h5);
  wire [2:0] nxt_sel = sel_legal ? wsel : `PBF_CLKO_RST;

  // port b control registers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      b_per_ff <= `PBF_B_PER_RST;
      b_ddr_ff <= '0;
      b_dr_ff <= '0;
      b_pur_ff <= `PBF_B_PUR_RST;
    end
    else if (ce_in)
    begin
      if (wr_b_per)
        b_per_ff <= wdata_in[NB-1:0];
      if (wr_b_ddr)
        b_ddr_ff <= wdata_in[NB-1:0];
      if (wr_b_dr)
        b_dr_ff <= wdata_in[NB-1:0];
      if (wr_b_pur)
        b_pur_ff <= wdata_in[NB-1:0];
    end
  end

  // port f control registers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      f_per_ff <= `PBF_F_PER_RST;
      f_ddr_ff <= '0;
      f_dr_ff <= '0;
      f_pur_ff <= `PBF_F_PUR_RST;
    end
    else if (ce_in)
    begin
      if (wr_f_per)
        f_per_ff <= wdata_in[NF-1:0];
      if (wr_f_ddr)
        f_ddr_ff <= wdata_in[NF-1:0];
      if (wr_f_dr)
        f_dr_ff <= wdata_in[NF-1:0];
      if (wr_f_pur)
        f_pur_ff <= wdata_in[NF-1:0];
    end
  end

  // clock-out select and bus drive control
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      clko_sel_ff <= pbf_pkg::PBF_CLKO_OFF;
      clko_addr_ff <= 1'b0;
      drv_ff <= `PBF_BUSCTL_RST;
    end
    else if (ce_in)
    begin
      if (wr_clko)
      begin
        clko_sel_ff <= pbf_pkg::pbf_clko_t'(nxt_sel);
        clko_addr_ff <= wdata_in[`PBF_CLKO_ADDR_BIT];
      end
      if (wr_busctl)
        drv_ff <= wdata_in[0];
    end
  end

  // clock sources live in other domains: two flops before any logic reads them
  // costs two cycles of monitor lag, but no metastable level reaches a pad
  logic [`PBF_SRC_W-1:0] src_meta_ff;
  logic [`PBF_SRC_W-1:0] src_sync_ff;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      src_meta_ff <= '0;
      src_sync_ff <= '0;
    end
    else if (ce_in)
    begin
      src_meta_ff <= {post_clk_in, pre_clk_in, osc_clk_in, ipb_clk_in, sys_clk_in};
      src_sync_ff <= src_meta_ff;
    end
  end

  // clock-out source select; sources are sampled, so this is a monitor only
  logic clko_src;
  always_comb
  begin
    clko_src = 1'b0;
    unique case (clko_sel_ff)
      pbf_pkg::PBF_CLKO_OFF: clko_src = 1'b0;
      pbf_pkg::PBF_CLKO_SYS: clko_src = src_sync_ff[`PBF_SRC_SYS];
      pbf_pkg::PBF_CLKO_IPB: clko_src = src_sync_ff[`PBF_SRC_IPB];
      pbf_pkg::PBF_CLKO_OSC: clko_src = src_sync_ff[`PBF_SRC_OSC];
      pbf_pkg::PBF_CLKO_PRE: clko_src = src_sync_ff[`PBF_SRC_PRE];
      pbf_pkg::PBF_CLKO_POST: clko_src = src_sync_ff[`PBF_SRC_POST];
      default: clko_src = 1'b0;
    endcase
  end

  // bus idle float: drive bit low means release pins while idle
  // the prescaler monitor on pin 4 is not a bus line, so it never floats
  wire bus_float = !bus_active_in && !drv_ff;

  // port b alternate function values
  logic [NB-1:0] b_alt_val;
  logic [NB-1:0] b_alt_oe;
  always_comb
  begin
    // address drive gated by bus float
    b_alt_val = addr_hi_in;
    b_alt_oe = {NB{!bus_float}};
    // pin 4 carries address or prescaler
    if (!clko_addr_ff)
    begin
      b_alt_val[`PBF_B_CLK_PIN] = src_sync_ff[`PBF_SRC_PRE];
      b_alt_oe[`PBF_B_CLK_PIN] = 1'b1;
    end
  end

  // data drive only while writing and not floated
  wire [NF-1:0] f_alt_oe = {NF{data_dir_out_in && !bus_float}};

  // port b select is high for gpio, port f select is high for the bus
  // per bit selects gpio when set on port b, the bus when set on port f
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++)
    begin : g_pb
      pbf_pin_cell u_cell (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .gpio_sel_in(b_per_ff[gi]),
        .gpio_dir_in(b_ddr_ff[gi]),
        .gpio_dat_in(b_dr_ff[gi]),
        .pu_en_in(b_pur_ff[gi]),
        .alt_val_in(b_alt_val[gi]),
        .alt_oe_in(b_alt_oe[gi]),
        .pad_in(pb_pad_in[gi]),
        .pad_out(pb_pad_out[gi]),
        .pad_oe_out(pb_pad_oe_out[gi]),
        .pad_pu_out(pb_pu_out[gi]),
        .sync_out(b_sync[gi])
      );
    end
    for (gi = 0; gi < NF; gi++)
    begin : g_pf
      pbf_pin_cell u_cell (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .gpio_sel_in(!f_per_ff[gi]),
        .gpio_dir_in(f_ddr_ff[gi]),
        .gpio_dat_in(f_dr_ff[gi]),
        .pu_en_in(f_pur_ff[gi]),
        .alt_val_in(data_wr_in[gi]),
        .alt_oe_in(f_alt_oe[gi]),
        .pad_in(pf_pad_in[gi]),
        .pad_out(pf_pad_out[gi]),
        .pad_oe_out(pf_pad_oe_out[gi]),
        .pad_pu_out(pf_pu_out[gi]),
        .sync_out(f_sync[gi])
      );
    end
  endgenerate

  // read mux; unmapped addresses read zero
  always_comb
  begin
    nxt_rdata = 16'h0000;
    unique case (addr_in)
      `PBF_ADDR_B_PER: nxt_rdata[NB-1:0] = b_per_ff;
      `PBF_ADDR_B_DDR: nxt_rdata[NB-1:0] = b_ddr_ff;
      `PBF_ADDR_B_DR: nxt_rdata[NB-1:0] = b_dr_ff;
      `PBF_ADDR_B_PUR: nxt_rdata[NB-1:0] = b_pur_ff;
      `PBF_ADDR_B_PIN: nxt_rdata[NB-1:0] = b_sync;
      `PBF_ADDR_F_PER: nxt_rdata[NF-1:0] = f_per_ff;
      `PBF_ADDR_F_DDR: nxt_rdata[NF-1:0] = f_ddr_ff;
      `PBF_ADDR_F_DR: nxt_rdata[NF-1:0] = f_dr_ff;
      `PBF_ADDR_F_PUR: nxt_rdata[NF-1:0] = f_pur_ff;
      `PBF_ADDR_F_PIN: nxt_rdata[NF-1:0] = f_sync;
      `PBF_ADDR_CLKO: nxt_rdata[3:0] = {clko_addr_ff, clko_sel_ff};
      `PBF_ADDR_BUSCTL: nxt_rdata[1:0] = {bus_active_in, drv_ff};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // read data, clock-out and float flops
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_out <= 16'h0000;
      clko_ff <= 1'b0;
      float_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      rdata_out <= rd_in ? nxt_rdata : 16'h0000;
      clko_ff <= clko_src;
      float_ff <= bus_float;
    end
  end

  assign clko_out = clko_ff;
  assign bus_float_out = float_ff;
  assign data_rd_out = f_sync;
endmodule : pbf_pin_mux
`default_nettype wire

// *** testbench/pbf_far_end.sv ***
// far-side model: external memory on the data pins, pull-ups and floating lines
`default_nettype none
module pbf_far_end #(
  parameter int N = 4
) (
  // clock
  input wire logic clk_in,
  // device side of the pads
  input wire logic [N-1:0] oe_in,
  input wire logic [N-1:0] dout_in,
  input wire logic [N-1:0] pu_in,
  // memory read cycle and its data
  input wire logic rd_in,
  input wire logic [N-1:0] mem_in,
  // resolved pad level
  output logic [N-1:0] lvl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [N-1:0] last_ff;
  logic [N-1:0] held;
  // an undriven line without pull-up shows the inverse of its last level
  assign held = rd_in ? mem_in : (pu_in | ~last_ff);
  assign lvl_out = (oe_in & dout_in) | (~oe_in & held);
  // only driven or pulled levels are kept, so a float does not toggle
  always_ff @(posedge clk_in)
    last_ff <= ((oe_in | pu_in) & lvl_out) | (~(oe_in | pu_in) & last_ff);
endmodule : pbf_far_end
`default_nettype wire

// *** testbench/pbf_pin_mux_props.sv ***
// assertion checker for the port b/f pin mux, bound to its top module
`default_nettype none
module pbf_chk #(
  parameter int NB = 5,
  parameter int NF = 4
) (
  // clock, reset, register writes
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  // bus side
  input wire logic bus_active_in,
  input wire logic [NB-1:0] addr_hi_in,
  // pads
  input wire logic [NB-1:0] pb_pad_out,
  input wire logic [NB-1:0] pb_pad_oe_out,
  input wire logic [NB-1:0] pb_pu_out,
  input wire logic [NF-1:0] pf_pad_oe_out,
  input wire logic [NF-1:0] pf_pu_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sh [12];
  logic idle;
  // shadow of writes; port b starts as gpio, port f as data bus
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      sh <= '{0: 16'h001f, 3: 16'h001f, 5: 16'h000f, 8: 16'h000f, 11: 16'h0001, default: '0};
    else if (ce_in && wr_in && addr_in < 4'hc)
      sh[addr_in] <= wdata_in;
  // idle bus with float selected
  assign idle = !bus_active_in && !sh[11][0];
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  property p_b_dir;
    (pb_pad_oe_out & $past(sh[0][NB-1:0])) == ($past(sh[1][NB-1:0]) & $past(sh[0][NB-1:0]));
  endproperty
  a_b_dir: assert property (p_b_dir) else $error("port b gpio enable wrong");
  property p_b_rst;
    $fell(rst_in) |-> (pb_pad_oe_out == '0)[*2];
  endproperty
  a_b_rst: assert property (p_b_rst) else $error("port b driven after reset");
  property p_b_pu;
    pb_pu_out == $past(sh[3][NB-1:0]);
  endproperty
  a_b_pu: assert property (p_b_pu) else $error("port b pull-up wrong");
  property p_pu_rst;
    $fell(rst_in) |-> pb_pu_out == '1 && pf_pu_out == '1;
  endproperty
  a_pu_rst: assert property (p_pu_rst) else $error("pull-ups off after reset");
  property p_a_float;
    idle[*3] |-> (pb_pad_oe_out & ~$past(sh[0][NB-1:0]) & {$past(sh[10][3]), 4'hf}) == '0;
  endproperty
  a_a_float: assert property (p_a_float) else $error("address pin driven on idle bus");
  property p_d_float;
    idle[*3] |-> (pf_pad_oe_out & $past(sh[5][NF-1:0])) == '0;
  endproperty
  a_d_float: assert property (p_d_float) else $error("data pin driven on idle bus");
  property p_f_dir;
    (pf_pad_oe_out & ~$past(sh[5][NF-1:0])) == ($past(sh[6][NF-1:0]) & ~$past(sh[5][NF-1:0]));
  endproperty
  a_f_dir: assert property (p_f_dir) else $error("port f gpio enable wrong");
  property p_pin4;
    (!sh[0][4] && sh[10][3] && $stable(addr_hi_in[4]))[*3] |->
      !pb_pad_oe_out[4] || pb_pad_out[4] == addr_hi_in[4];
  endproperty
  a_pin4: assert property (p_pin4) else $error("pin 4 not carrying address");
endmodule : pbf_chk
bind pbf_pin_mux pbf_chk #(.NB(NB), .NF(NF)) i_chk (
  .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .bus_active_in(bus_active_in), .addr_hi_in(addr_hi_in),
  .pb_pad_out(pb_pad_out), .pb_pad_oe_out(pb_pad_oe_out), .pb_pu_out(pb_pu_out),
  .pf_pad_oe_out(pf_pad_oe_out), .pf_pu_out(pf_pu_out));
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the port b/f pin mux
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, bus_active_in = 1'b0;
  logic dir_w = 1'b0, ce = 1'b1, flt, clko;
  logic [3:0] mem_dat = 4'h6;
  logic [3:0] addr_in = 4'h0, data_wr = 4'h0, data_rd, pf_out, pf_oe, pf_pu, pf_in;
  logic [15:0] wdata_in = 16'h0000, rdata_out;
  logic [4:0] addr_hi = 5'h00, src = 5'h00, pb_out, pb_oe, pb_pu, pb_in;
  int miscompares = 0, n_checks = 0;
  // write, pad latency wait, read: {wa, wd, ra, expected}
  logic [23:0] rows [18] = '{24'hf00_01f, 24'hf00_31f, 24'hf00_50f, 24'hf00_b01, 24'hf00_c00,
    24'h115_115, 24'h211_41b, 24'h315_411, 24'h500_500, 24'h605_605, 24'h701_90b,
    24'ha01_a01, 24'ha02_a02, 24'ha03_a03, 24'ha04_a04, 24'ha05_a05, 24'ha06_a00, 24'ha00_a00};
  always #2.5 clk_in = ~clk_in;
  pbf_pin_mux i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .bus_active_in(bus_active_in), .addr_hi_in(addr_hi), .data_wr_in(data_wr),
    .data_dir_out_in(dir_w), .data_rd_out(data_rd), .bus_float_out(flt), .sys_clk_in(src[0]),
    .ipb_clk_in(src[1]), .osc_clk_in(src[2]), .pre_clk_in(src[3]), .post_clk_in(src[4]),
    .clko_out(clko), .pb_pad_in(pb_in), .pb_pad_out(pb_out), .pb_pad_oe_out(pb_oe),
    .pb_pu_out(pb_pu), .pf_pad_in(pf_in), .pf_pad_out(pf_out), .pf_pad_oe_out(pf_oe),
    .pf_pu_out(pf_pu));
  pbf_far_end #(.N(5)) i_pb (.clk_in(clk_in), .oe_in(pb_oe), .dout_in(pb_out), .pu_in(pb_pu),
    .rd_in(1'b0), .mem_in(5'h00), .lvl_out(pb_in));
  pbf_far_end #(.N(4)) i_pf (.clk_in(clk_in), .oe_in(pf_oe), .dout_in(pf_out), .pu_in(pf_pu),
    .rd_in(bus_active_in & ~dir_w), .mem_in(mem_dat), .lvl_out(pf_in));
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
  endtask : rd
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // main sequence: table first, then bus, enable, pin 4 and reset cases
  initial
  begin
    logic [15:0] v;
    logic [3:0] wa, ra;
    logic [7:0] wd, ex;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (rows[i])
    begin
      {wa, wd, ra, ex} = rows[i];
      @(posedge clk_in);
      src <= (wd[2:0] inside {[1:5]}) ? 5'h01 << (wd[2:0] - 3'h1) : 5'h1f;
      wr(wa, {8'h00, wd});
      repeat (4) @(posedge clk_in);
      rd(ra, v);
      chk("reg", v, ex);
      if (wa == 4'ha)
        chk("clko", clko, (wd[2:0] inside {[1:5]}));
    end
    $display("table done");
    wr(4'h0, 16'h0000);
    wr(4'ha, 16'h0008);
    wr(4'h5, 16'h000f);
    wr(4'hb, 16'h0000);
    repeat (4) @(negedge clk_in);
    chk("idle", {pb_oe, pf_oe, flt}, 10'h001);
    @(posedge clk_in);
    bus_active_in <= 1'b1;
    addr_hi <= 5'h15;
    data_wr <= 4'ha;
    dir_w <= 1'b1;
    repeat (4) @(negedge clk_in);
    chk("busy", {pb_oe, pb_out, pf_oe, pf_out}, 18'h3f5fa);
    @(posedge clk_in);
    dir_w <= 1'b0;
    mem_dat <= 4'h9;
    repeat (5) @(negedge clk_in);
    chk("read", {pf_oe, data_rd}, 8'h09);
    $display("bus test done");
    // enable low: a write in that cycle must not land
    @(posedge clk_in);
    ce <= 1'b0;
    wr(4'h1, 16'h000a);
    ce <= 1'b1;
    rd(4'h1, v);
    chk("frozen ddr", v, 16'h0015);
    $display("enable test done");
    @(posedge clk_in);
    bus_active_in <= 1'b0;
    src <= 5'h08;
    wr(4'ha, 16'h0004);
    repeat (4) @(negedge clk_in);
    chk("pin4 hi", {pb_oe[4], pb_out[4]}, 2'b11);
    @(posedge clk_in);
    src <= 5'h00;
    repeat (4) @(negedge clk_in);
    chk("pin4 lo", {pb_oe[4], pb_out[4]}, 2'b10);
    $display("pin 4 test done");
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(negedge clk_in);
    chk("reset", {pb_pu, pf_pu, pb_oe, pf_oe}, 18'h3fe00);
    @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(negedge clk_in);
    chk("pads after reset", {pb_oe, pf_oe}, 9'h000);
    rd(4'h0, v);
    chk("gpio after reset", v, 16'h001f);
    $display("reset test done");
    test_done();
  end
  // watchdog far beyond the expected run length
  initial
  begin
    #20000;
    miscompares++;
    $display("FAIL watchdog expired");
    test_done();
  end
endmodule : testbench
`default_nettype wire
